/* src/dcc_pkg.sv */
/*
 * Shared constants and carrier types for the dual comparator control
 * block: register offsets, field positions, reset values and the
 * structs that carry the analog steering and pad signals.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package dcc_pkg;

    // bus geometry
    localparam int unsigned DATA_W = 32;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned OFF_W = 4;

    // register byte offsets
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h4;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h8;

    // control/status field positions, comparator 1 at the base
    localparam int unsigned BIT_SUPPRESS = 15;
    localparam int unsigned BIT_UNUSED = 14;
    localparam int unsigned BIT_FLAG = 12;
    localparam int unsigned BIT_EN = 10;
    localparam int unsigned BIT_PAD = 8;
    localparam int unsigned BIT_RESULT = 6;
    localparam int unsigned BIT_INV = 4;
    localparam int unsigned BIT_POS = 0;
    localparam int unsigned BIT_NEG = 1;
    localparam int unsigned SEL_STRIDE = 2;

    // writable storage bits: 15, 11..8, 5..0
    localparam logic [15:0] CTRL_WMASK = 16'h8f3f;

    // reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [1:0] FLAG_RST = 2'h0;
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam logic [31:0] RD_RST = 32'h0000_0000;

    // steering towards the analog comparators, bit 0 = comparator 1
    typedef struct packed {
        logic [1:0] enable;
        logic [1:0] pos_select;
        logic [1:0] neg_select;
    } dcc_analog_t;

    // output pads, bit 0 = comparator 1
    typedef struct packed {
        logic [1:0] value;
        logic [1:0] drive;
    } dcc_pad_t;

endpackage : dcc_pkg

/* src/dcc_chan.sv */
/*
 * One comparator channel: gating, output inversion, registered
 * result and a one-cycle change pulse.
 * Assumes the raw comparator decision is synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module dcc_chan (
    input wire logic clk,
    input wire logic rstn,
    input wire logic raw,
    input wire logic enable,
    input wire logic invert,
    output var logic result_q,
    output var logic change_q
);
    logic result_d;

    // inversion ahead of status, pad and change detection
    always_comb begin
        result_d = enable ? (raw ^ invert) : 1'b0;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            result_q <= 1'b0;
        end else begin
            result_q <= result_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            change_q <= 1'b0;
        end else begin
            change_q <= enable && (result_d != result_q);
        end
    end

    sense_plain_a: assert property (@(posedge clk) disable iff (!rstn)
        enable && !invert |=> result_q == $past(raw))
        else $error("result does not follow comparator");

    sense_inv_a: assert property (@(posedge clk) disable iff (!rstn)
        enable && invert |=> result_q == !$past(raw))
        else $error("inverted result wrong");

    off_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        !enable |=> !result_q && !change_q)
        else $error("disabled comparator shows activity");

endmodule : dcc_chan

`default_nettype wire

/* src/dcc_top.sv */
/*
 * Dual comparator control: control/status register, change flags,
 * interrupt status and mask, analog steering and pad drive, all
 * reached over a classic Wishbone slave.
 * Assumes the analog comparators and the reference level sit outside
 * and that comparator decisions and idle_mode are synchronous to clk.
 */
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module dcc_top #(
    parameter int unsigned ADR_W = 8,
    parameter int unsigned N_CMP = 2
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADR_W-1:0] wb_adr,
    input wire logic [dcc_pkg::SEL_W-1:0] wb_sel,
    input wire logic [dcc_pkg::DATA_W-1:0] wb_dat_w,
    output var logic [dcc_pkg::DATA_W-1:0] wb_dat_r,
    output var logic wb_ack,
    input wire logic [1:0] cmp_raw,
    input wire logic idle_mode,
    output dcc_pkg::dcc_analog_t analog,
    output dcc_pkg::dcc_pad_t pad,
    output var logic irq
);
    import dcc_pkg::*;

    // register layout is fixed at two comparators
    if (N_CMP != 2) begin : g_bad_cmp
        $error("dcc_top serves exactly two comparators");
    end
    if (ADR_W <= OFF_W) begin : g_bad_adr
        $error("dcc_top needs more than four address bits");
    end

    function automatic logic hit(input logic [ADR_W-1:0] a,
                                 input logic [3:0] off);
        return (a[ADR_W-1:OFF_W] == '0) && (a[OFF_W-1:0] == off);
    endfunction : hit

    logic ack_q;
    logic [DATA_W-1:0] rd_q;
    logic [DATA_W-1:0] rd_d;
    logic [15:0] ctrl_q;
    logic [1:0] flag_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic [1:0] res;
    logic [1:0] chg;
    logic req;
    logic wr_go;
    logic ctrl_wr;
    logic stat_wr;
    logic mask_wr;
    logic quiet;
    logic [15:0] ctrl_view;

    // bus decode
    assign req = wb_cyc && wb_stb;
    assign wr_go = req && ack_q && wb_we;
    assign ctrl_wr = wr_go && hit(wb_adr, OFF_CTRL);
    assign stat_wr = wr_go && hit(wb_adr, OFF_IRQ_STAT);
    assign mask_wr = wr_go && hit(wb_adr, OFF_IRQ_MASK);

    // one wait cycle, ack drops the cycle after
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end
    assign wb_ack = ack_q;

    // comparator channels
    for (genvar i = 0; i < 2; i++) begin : g_chan
        dcc_chan u_chan (
            .clk(clk),
            .rstn(rstn),
            .raw(cmp_raw[i]),
            .enable(ctrl_q[BIT_EN+i]),
            .invert(ctrl_q[BIT_INV+i]),
            .result_q(res[i]),
            .change_q(chg[i])
        );
    end

    // writable control bits, per byte lane
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= CTRL_RST;
        end else if (ctrl_wr) begin
            if (wb_sel[0]) begin
                ctrl_q[7:0] <= wb_dat_w[7:0] & CTRL_WMASK[7:0];
            end
            if (wb_sel[1]) begin
                ctrl_q[15:8] <= wb_dat_w[15:8] & CTRL_WMASK[15:8];
            end
        end
    end

    // change flags: set wins over a zero write
    for (genvar i = 0; i < 2; i++) begin : g_flag
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                flag_q[i] <= FLAG_RST[i];
            end else if (chg[i]) begin
                flag_q[i] <= 1'b1;
            end else if (ctrl_wr && wb_sel[1]
                         && !wb_dat_w[BIT_FLAG+i]) begin
                flag_q[i] <= 1'b0;
            end
        end
    end

    // interrupt status, write one to clear, set wins
    for (genvar i = 0; i < 2; i++) begin : g_stat
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                irq_stat_q[i] <= IRQ_RST[i];
            end else if (chg[i]) begin
                irq_stat_q[i] <= 1'b1;
            end else if (stat_wr && wb_sel[0] && wb_dat_w[i]) begin
                irq_stat_q[i] <= 1'b0;
            end
        end
    end

    // interrupt mask
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_mask_q <= IRQ_RST;
        end else if (mask_wr && wb_sel[0]) begin
            irq_mask_q <= wb_dat_w[1:0];
        end
    end

    // idle suppression gates only the request line
    assign quiet = idle_mode && ctrl_q[BIT_SUPPRESS];
    assign irq = |(irq_stat_q & irq_mask_q) && !quiet;

    // control/status view, bit 14 never stored
    assign ctrl_view = ctrl_q
                     | ({14'h0000, flag_q} << BIT_FLAG)
                     | ({14'h0000, res} << BIT_RESULT);

    // read data, unmapped reads zero
    always_comb begin
        rd_d = RD_RST;
        if (hit(wb_adr, OFF_CTRL)) begin
            rd_d = {16'h0000, ctrl_view};
        end else if (hit(wb_adr, OFF_IRQ_STAT)) begin
            rd_d = {30'h0000_0000, irq_stat_q};
        end else if (hit(wb_adr, OFF_IRQ_MASK)) begin
            rd_d = {30'h0000_0000, irq_mask_q};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_q <= RD_RST;
        end else if (req && !ack_q) begin
            rd_q <= rd_d;
        end
    end
    assign wb_dat_r = rd_q;

    // analog steering and pads
    assign analog.enable = ctrl_q[BIT_EN +: 2];
    assign analog.pos_select = {ctrl_q[BIT_POS+SEL_STRIDE],
                                ctrl_q[BIT_POS]};
    assign analog.neg_select = {ctrl_q[BIT_NEG+SEL_STRIDE],
                                ctrl_q[BIT_NEG]};
    assign pad.value = res;
    assign pad.drive = ctrl_q[BIT_PAD +: 2];

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence hi_wr_s;
        ctrl_wr && wb_sel[1];
    endsequence

    sequence lo_wr_s;
        ctrl_wr && wb_sel[0];
    endsequence

    sequence read_ctrl_s;
        req && !ack_q && hit(wb_adr, OFF_CTRL);
    endsequence

    bus_ack_a: assert property (
        req && !ack_q |=> wb_ack ##1 !wb_ack)
        else $error("ack not one cycle after request");

    enable_wr_a: assert property (
        hi_wr_s |=> analog.enable == $past(wb_dat_w[BIT_EN +: 2]))
        else $error("enable write not applied");

    pad_wr_a: assert property (
        hi_wr_s |=> pad.drive == $past(wb_dat_w[BIT_PAD +: 2]))
        else $error("pad drive write not applied");

    pos_sel_a: assert property (
        lo_wr_s |=> analog.pos_select
            == {$past(wb_dat_w[BIT_POS+SEL_STRIDE]),
                $past(wb_dat_w[BIT_POS])})
        else $error("positive select write not applied");

    neg_sel_a: assert property (
        lo_wr_s |=> analog.neg_select
            == {$past(wb_dat_w[BIT_NEG+SEL_STRIDE]),
                $past(wb_dat_w[BIT_NEG])})
        else $error("negative select write not applied");

    unused_zero_a: assert property (
        wb_ack |-> !wb_dat_r[BIT_UNUSED])
        else $error("bit 14 read as one");

    read_res_a: assert property (
        read_ctrl_s |=> wb_dat_r[BIT_RESULT +: 2] == $past(res))
        else $error("result bits misreported");

    flag_set_a: assert property (
        chg[0] |=> flag_q[0] ##0 irq_stat_q[0])
        else $error("comparator 1 change not flagged");

    flag2_set_a: assert property (
        chg[1] |=> flag_q[1])
        else $error("comparator 2 change not flagged");

    flag_hold_a: assert property (
        flag_q[0] && !(ctrl_wr && wb_sel[1]) |=> flag_q[0])
        else $error("change flag dropped without write");

    flag_clr_a: assert property (
        hi_wr_s ##0 (!chg[1] && !wb_dat_w[BIT_FLAG+1])
        |=> !flag_q[1])
        else $error("zero write left flag set");

    idle_quiet_a: assert property (
        idle_mode && ctrl_q[BIT_SUPPRESS] |-> !irq)
        else $error("interrupt raised while suppressed in idle");

    irq_raise_a: assert property (
        chg[0] ##1 (irq_mask_q[0] && !quiet) |-> irq)
        else $error("unmasked change did not raise interrupt");

    // status, mask and other-channel counterparts
    sequence stat_wr_s;
        stat_wr && wb_sel[0];
    endsequence

    sequence mask_wr_s;
        mask_wr && wb_sel[0];
    endsequence

    sequence quiet_end_s;
        quiet ##1 !quiet;
    endsequence

    flag_hold2_a: assert property (
        flag_q[1] && !(ctrl_wr && wb_sel[1]) |=> flag_q[1])
        else $error("comparator 2 flag dropped without write");

    flag_clr1_a: assert property (
        hi_wr_s ##0 (!chg[0] && !wb_dat_w[BIT_FLAG])
        |=> !flag_q[0])
        else $error("zero write left comparator 1 flag set");

    irq2_raise_a: assert property (
        chg[1] ##1 (irq_mask_q[1] && !quiet) |-> irq)
        else $error("comparator 2 change did not raise interrupt");

    stat_clr_a: assert property (
        stat_wr_s ##0 (wb_dat_w[0] && !chg[0]) |=> !irq_stat_q[0])
        else $error("status bit not cleared by a one");

    stat_keep_a: assert property (
        irq_stat_q[1] && !(stat_wr && wb_sel[0]) |=> irq_stat_q[1])
        else $error("status bit dropped without write");

    mask_wr_a: assert property (
        mask_wr_s |=> irq_mask_q == $past(wb_dat_w[1:0]))
        else $error("mask write not applied");

    // idle handling
    idle_run_a: assert property (
        quiet && chg[0] |=> irq_stat_q[0] && flag_q[0])
        else $error("change lost while suppressed in idle");

    idle_end_a: assert property (
        quiet_end_s ##0 (|(irq_stat_q & irq_mask_q)) |-> irq)
        else $error("pending interrupt missing after idle");

    // control register fields
    unused_wr_a: assert property (
        hi_wr_s ##0 wb_dat_w[BIT_UNUSED]
        |=> !ctrl_view[BIT_UNUSED])
        else $error("bit 14 stored");

    ro_result_a: assert property (
        lo_wr_s |=> ctrl_view[BIT_RESULT +: 2] == res)
        else $error("result bits writable");

    inv_wr_a: assert property (
        lo_wr_s |=> ctrl_q[BIT_INV +: 2]
            == $past(wb_dat_w[BIT_INV +: 2]))
        else $error("invert write not applied");

    suppress_wr_a: assert property (
        hi_wr_s |=> ctrl_q[BIT_SUPPRESS]
            == $past(wb_dat_w[BIT_SUPPRESS]))
        else $error("idle suppress write not applied");

    lane_keep_a: assert property (
        ctrl_wr && !wb_sel[0]
        |=> ctrl_q[7:0] == $past(ctrl_q[7:0]))
        else $error("low byte changed without its lane");

    // bus side
    ack_quiet_a: assert property (
        !req |=> !wb_ack)
        else $error("ack without request");

    miss_read_a: assert property (
        req && !ack_q && !hit(wb_adr, OFF_CTRL)
        && !hit(wb_adr, OFF_IRQ_STAT) && !hit(wb_adr, OFF_IRQ_MASK)
        |=> wb_dat_r == RD_RST)
        else $error("unmapped place read nonzero");

    rd_keep_a: assert property (
        !(req && !ack_q) |=> $stable(wb_dat_r))
        else $error("read data moved between requests");

endmodule : dcc_top

`default_nettype wire

/* bench/tb_top.sv */
/*
 * Self-checking bench for dcc_top: register access, change flags,
 * interrupt mask, status clear and idle suppression.
 * Assumes dcc_pkg and dcc_top are compiled before this file.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import dcc_pkg::*;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0000_0000;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    logic [1:0] cmp_raw = 2'h0;
    logic idle_mode = 1'b0;
    dcc_analog_t analog;
    dcc_pad_t pad;
    logic irq;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] rdata;

    dcc_top dut (
        .clk(clk),
        .rstn(rstn),
        .wb_cyc(wb_cyc),
        .wb_stb(wb_stb),
        .wb_we(wb_we),
        .wb_adr(wb_adr),
        .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w),
        .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack),
        .cmp_raw(cmp_raw),
        .idle_mode(idle_mode),
        .analog(analog),
        .pad(pad),
        .irq(irq)
    );

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count = fail_count + 1;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // one classic cycle, held until ack is sampled
    task automatic bus(input logic we, input logic [7:0] adr,
                       input logic [15:0] d, input logic [3:0] sel);
        int n;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= sel;
        wb_dat_w <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (wb_ack !== 1'b1) begin
            fail_count++;
        end
        rdata = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] adr, input logic [15:0] d);
        bus(1'b1, adr, d, 4'h3);
    endtask : wr

    task automatic rd(input logic [7:0] adr, input logic [15:0] exp,
                      input logic [15:0] mask);
        bus(1'b0, adr, 16'h0000, 4'h3);
        chk(rdata & {16'h0000, mask}, {16'h0000, exp});
    endtask : rd

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h00, 16'h0000, 16'hffff);
        rd(8'h04, 16'h0000, 16'hffff);
        rd(8'h08, 16'h0000, 16'hffff);
        chk(32'(analog), 32'h0000_0000);
        chk(32'(pad), 32'h0000_0000);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        // all ones: bit 14 and flag writes ignored, invert flips result
        wr(8'h00, 16'hffff);
        tick(4);
        rd(8'h00, 16'hbfff, 16'hffff);
        chk(32'(analog), 32'h0000_003f);
        chk(32'(pad), 32'h0000_000f);
        // plain setup, flags cleared by writing zero
        wr(8'h00, 16'h0c05);
        tick(4);
        wr(8'h00, 16'h0c05);
        wr(8'h04, 16'h0003);
        tick(2);
        rd(8'h00, 16'h0c05, 16'hffff);
        rd(8'h04, 16'h0000, 16'hffff);
        chk(32'(analog), 32'h0000_003c);
        chk(32'(pad), 32'h0000_0000);
        wr(8'h08, 16'h0003);
        for (int i = 0; i < 2; i++) begin
            cmp_raw <= 2'(1 << i);
            tick(4);
            rd(8'h00, 16'h0c05 | (16'h1040 << i), 16'hffff);
            rd(8'h04, 16'(1 << i), 16'hffff);
            chk({31'h0000_0000, irq}, 32'h0000_0001);
            idle_mode <= 1'b1;
            tick(2);
            chk({31'h0000_0000, irq}, 32'h0000_0001);
            wr(8'h00, 16'h8c05);
            tick(2);
            chk({31'h0000_0000, irq}, 32'h0000_0000);
            idle_mode <= 1'b0;
            tick(2);
            chk({31'h0000_0000, irq}, 32'h0000_0001);
            rd(8'h00, 16'h8c05 | (16'h0040 << i), 16'hffff);
            wr(8'h04, 16'(1 << i));
            tick(2);
            chk({31'h0000_0000, irq}, 32'h0000_0000);
            wr(8'h00, 16'h0c05);
            cmp_raw <= 2'h0;
            tick(4);
            wr(8'h00, 16'h0c05);
            wr(8'h04, 16'h0003);
            tick(2);
        end
        // change while suppressed in idle: status still records it
        idle_mode <= 1'b1;
        wr(8'h00, 16'h8c05);
        cmp_raw <= 2'h1;
        tick(4);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rd(8'h04, 16'h0001, 16'hffff);
        idle_mode <= 1'b0;
        tick(2);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        cmp_raw <= 2'h0;
        tick(4);
        wr(8'h00, 16'h0c05);
        wr(8'h04, 16'h0003);
        tick(2);
        // inversion on, inputs low: results read high
        wr(8'h00, 16'h0c35);
        tick(4);
        rd(8'h00, 16'h00c0, 16'h00c0);
        // disabled comparators report zero
        cmp_raw <= 2'h3;
        wr(8'h00, 16'h0000);
        tick(4);
        rd(8'h00, 16'h0000, 16'h00c0);
        chk(32'(pad), 32'h0000_0000);
        // unmapped place
        wr(8'h0c, 16'hffff);
        rd(8'h0c, 16'h0000, 16'hffff);
        // upper byte lane only
        bus(1'b1, 8'h00, 16'h0f3f, 4'h2);
        tick(2);
        rd(8'h00, 16'h0f00, 16'h8f3f);
        // reset in mid-run clears everything
        rstn <= 1'b0;
        tick(2);
        chk(32'(analog), 32'h0000_0000);
        chk(32'(pad), 32'h0000_0000);
        chk(wb_dat_r, 32'h0000_0000);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rstn <= 1'b1;
        rd(8'h00, 16'h0000, 16'hffff);
        rd(8'h08, 16'h0000, 16'hffff);
        close_out();
    end

endmodule : tb_top

`default_nettype wire
